// [design/clk_switch_cfg.svh]
// Constants for the CPU clock source switcher: field positions, reset values and timings.
`ifndef CLK_SWITCH_CFG_SVH
`define CLK_SWITCH_CFG_SVH

// Field positions.
`define HS_STOP_BIT        7
`define LS_STOP_BIT        0
`define SRC_SELECT_BIT     0
`define SRC_STATUS_BIT     1
`define DIV_MSB            2
`define DIV_LSB            0

// Reset values and the largest legal divider code.
`define HS_STOP_RST        1'h0
`define LS_STOP_RST        1'h0
`define SRC_SELECT_RST     1'h0
`define DIV_RST            3'h0
`define DIV_MAX_CODE       3'h4

// Timing.
`define CLK_SYS_MHZ        100
`define HS_INT_WAIT_US     350
`define HS_INT_WAIT_CYC    (`HS_INT_WAIT_US * `CLK_SYS_MHZ)
`define LS_FREQ_WORST_KHZ  120
`define START_LS_CLOCKS    5'h11
`define TO_HIGH_CPU_CLOCKS 2'h2
`define WDT_PERIOD_LS      16'h0400
`define WDT_RST_HOLD       4'h8

`endif

// [design/clk_switch_pkg.sv]
// Types shared by the CPU clock source switcher.
package clk_switch_pkg;

  // Switchover progress, one-hot.
  typedef enum logic [1:0] {
    SW_IDLE = 2'b01,
    SW_WAIT = 2'b10
  } switch_state_t;

  // Reset and start-up phase, one-hot.
  typedef enum logic [2:0] {
    PH_RESET = 3'b001,
    PH_START = 3'b010,
    PH_RUN   = 3'b100
  } start_phase_t;

  typedef logic [2:0] div_code_t;

endpackage

// [design/cpu_tick_divider.sv]
// Divides a source clock tick by a power of two for the CPU clock.
`timescale 1ns/1ps
`include "clk_switch_cfg.svh"

module cpu_tick_divider
  import clk_switch_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input  wire logic      clk_sys,    // System clock.
  input  wire logic      sys_rst,    // Synchronous reset, active high.
  input  wire logic      srcTick,    // One pulse per source clock.
  input  wire logic      runEnable,  // High while the CPU may be clocked.
  input  wire div_code_t codeIn,     // Divider code last written.
  output logic           tickOut,    // One pulse per CPU clock.
  output div_code_t      activeCode  // Division now in effect.
);

  logic [CNT_W-1:0] phaseCnt;

  // Limit of the phase counter for a code: two to the code, minus one.
  function automatic logic [CNT_W-1:0] phaseLimit(input div_code_t code);
    phaseLimit = CNT_W'((1 << code) - 1);
  endfunction

  // A new code is taken only at the end of a CPU period, so the old division
  // never lasts longer than one old CPU clock and never yields a runt period.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phaseCnt   <= '0;
      tickOut    <= 1'h0;
      activeCode <= `DIV_RST;
    end else begin
      tickOut <= 1'h0;
      if (srcTick) begin
        if (phaseCnt >= phaseLimit(activeCode)) begin
          phaseCnt   <= '0;
          tickOut    <= runEnable;
          activeCode <= codeIn;
        end else begin
          phaseCnt <= phaseCnt + CNT_W'(1);
        end
      end
    end
  end

endmodule // cpu_tick_divider

// [design/cpu_clock_source_switcher.sv]
// CPU clock source selection, oscillator gating, divider and reset sequencing.
`timescale 1ns/1ps
`include "clk_switch_cfg.svh"

module cpu_clock_source_switcher
  import clk_switch_pkg::*;
#(
  parameter logic [15:0] WDT_PERIOD = `WDT_PERIOD_LS,  // Watchdog period in low-speed clocks.
  parameter logic [3:0]  RST_HOLD   = `WDT_RST_HOLD    // Watchdog reset length in cycles.
) (
  input  wire logic      clk_sys,               // System clock, 100 MHz.
  input  wire logic      sys_rst,               // Synchronous reset, active high.
  input  wire logic      resetPinN,             // External reset pin, active low.
  input  wire logic      powerOnClear,          // Power-on clear request, active high.
  input  wire logic      lowVoltageDetect,      // Low-voltage detect request, active high.
  input  wire logic      lowSpeedClkIn,         // Low-speed oscillator output pin.
  input  wire logic      crystalOscInput,       // High-speed oscillator output pin.
  input  wire logic      lowSpeedStoppable,     // Option: low-speed oscillator may be stopped.
  input  wire logic      selectWrite,           // Write strobe for the select bit.
  input  wire logic      selectData,            // Value for the select bit.
  input  wire logic      hsStopWrite,           // Write strobe for the high-speed stop flag.
  input  wire logic      hsStopData,            // Value for the high-speed stop flag.
  input  wire logic      lsStopWrite,           // Write strobe for the low-speed stop flag.
  input  wire logic      lsStopData,            // Value for the low-speed stop flag.
  input  wire logic      divWrite,              // Write strobe for the divider field.
  input  wire div_code_t divData,               // Value for the divider field.
  input  wire logic      stopMode,              // CPU is in STOP mode.
  input  wire logic      haltMode,              // CPU is in HALT mode.
  input  wire logic      watchdogClear,         // Software clears the watchdog.
  output logic           cpuClockSourceSelect,  // Select bit readback.
  output logic           cpuClockSourceStatus,  // Clock the CPU runs on.
  output logic           highSpeedOscStop,      // High-speed stop flag readback.
  output logic           lowSpeedOscStop,       // Low-speed stop flag readback.
  output div_code_t      cpuDividerCode,        // Divider field readback.
  output div_code_t      cpuDividerActive,      // Division now in effect.
  output logic           highSpeedOscEnable,    // Runs the high-speed oscillator.
  output logic           lowSpeedOscEnable,     // Runs the low-speed oscillator.
  output logic           cpuClkTick,            // One pulse per CPU clock.
  output logic           periphClkTick,         // One pulse per peripheral clock.
  output logic           switchBusy,            // Source switch in progress.
  output logic           watchdogOverflow,      // Watchdog overflowed, one-cycle pulse.
  output logic           internalReset          // Device held in reset.
);

  // Synchronisers: bit 0 reset pin, 1 power-on, 2 low voltage, 3 low clock, 4 high clock.
  logic [4:0]    syncFirst;
  logic [4:0]    syncSecond;
  logic [1:0]    clkPrev;
  logic          lsTick;
  logic          hsTick;
  logic          resetActive;
  logic          blockRst;
  logic [3:0]    wdtRstCnt;
  logic [15:0]   wdtCnt;
  logic          wdtRun;
  start_phase_t  phase;
  logic [4:0]    startCnt;
  switch_state_t swState;
  logic [1:0]    swCnt;
  logic          srcTick;
  logic          divTick;
  logic          cpuRun;
  logic          haltSource;
  logic          next_hsEnable;
  logic          next_lsEnable;
  logic          next_periphTick;

  // The pins and oscillator outputs are asynchronous to clk_sys.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      syncFirst  <= 5'h01;
      syncSecond <= 5'h01;
    end else begin
      syncFirst  <= {crystalOscInput, lowSpeedClkIn, lowVoltageDetect, powerOnClear,
                     resetPinN};
      syncSecond <= syncFirst;
    end
  end

  // Edge detection on the synchronised oscillator levels. A stopped oscillator
  // gives no edges, and the enables gate any that still leak through.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clkPrev <= 2'h0;
    end else begin
      clkPrev <= syncSecond[4:3];
    end
  end

  assign lsTick = syncSecond[3] & ~clkPrev[0] & lowSpeedOscEnable;
  assign hsTick = syncSecond[4] & ~clkPrev[1] & highSpeedOscEnable;

  // Any reset source holds the whole block; the watchdog source is stretched
  // so that the reset it causes has a defined length.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resetActive <= 1'h1;
      wdtRstCnt   <= 4'h0;
    end else begin
      if (watchdogOverflow) begin
        wdtRstCnt <= RST_HOLD;
      end else if (wdtRstCnt != 4'h0) begin
        wdtRstCnt <= wdtRstCnt - 4'h1;
      end
      resetActive <= ~syncSecond[0] | syncSecond[1] | syncSecond[2]
                     | watchdogOverflow | (wdtRstCnt != 4'h0);
    end
  end

  assign blockRst = sys_rst | resetActive;

  // The reset output mirrors the combined reset sources.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      internalReset <= 1'h1;
    end else begin
      internalReset <= resetActive;
    end
  end

  // After release the CPU waits for 17 low-speed clocks before it is clocked.
  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      phase    <= PH_RESET;
      startCnt <= 5'h00;
    end else begin
      case (phase)
        PH_RESET: begin
          phase <= PH_START;
        end
        PH_START: begin
          if (lsTick) begin
            startCnt <= startCnt + 5'h01;
            if (startCnt == `START_LS_CLOCKS - 5'h01) begin
              phase <= PH_RUN;
            end
          end
        end
        PH_RUN: begin
          phase <= PH_RUN;
        end
        default: begin
          phase <= PH_RESET;
        end
      endcase
    end
  end

  // Software-visible control bits. Writes during reset are lost on purpose,
  // since the CPU is not clocked then.
  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      cpuClockSourceSelect <= `SRC_SELECT_RST;
      highSpeedOscStop     <= `HS_STOP_RST;
      lowSpeedOscStop      <= `LS_STOP_RST;
      cpuDividerCode       <= `DIV_RST;
    end else begin
      if (selectWrite) begin
        cpuClockSourceSelect <= selectData;
      end
      if (hsStopWrite) begin
        highSpeedOscStop <= hsStopData;
      end
      if (lsStopWrite) begin
        lowSpeedOscStop <= lsStopData;
      end
      if (divWrite && divData <= `DIV_MAX_CODE) begin
        cpuDividerCode <= divData;
      end
    end
  end

  // Oscillator enables. The high-speed flag is ignored while it clocks the CPU,
  // the low-speed flag while that one does, so the CPU never loses its clock.
  always_comb begin
    next_hsEnable = ~resetActive & ~stopMode
                    & ~(highSpeedOscStop & ~cpuClockSourceStatus);
    next_lsEnable = ~resetActive
                    & ~(lowSpeedStoppable & lowSpeedOscStop
                        & cpuClockSourceStatus);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      highSpeedOscEnable <= 1'h0;
      lowSpeedOscEnable  <= 1'h0;
    end else begin
      highSpeedOscEnable <= next_hsEnable;
      lowSpeedOscEnable  <= next_lsEnable;
    end
  end

  // Source switch. Going up, the move happens on the second old CPU clock.
  // Going down, it waits for a low-speed edge after one old CPU clock, which
  // bounds it by the frequency ratio plus one; a halved CPU clock halves it.
  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      swState              <= SW_IDLE;
      swCnt                <= 2'h0;
      cpuClockSourceStatus <= 1'h0;
    end else begin
      case (swState)
        SW_IDLE: begin
          swCnt <= 2'h0;
          if (cpuClockSourceSelect != cpuClockSourceStatus) begin
            swState <= SW_WAIT;
            // A CPU clock in the cycle after the write already counts, so the bound holds.
            if (cpuClkTick) begin
              swCnt <= 2'h1;
            end
          end
        end
        SW_WAIT: begin
          if (cpuClockSourceSelect == cpuClockSourceStatus) begin
            swState <= SW_IDLE;
          end else if (cpuClockSourceSelect) begin
            if (cpuClkTick) begin
              swCnt <= swCnt + 2'h1;
              if (swCnt == `TO_HIGH_CPU_CLOCKS - 2'h1) begin
                cpuClockSourceStatus <= 1'h1;
                swState              <= SW_IDLE;
              end
            end
          end else begin
            if (cpuClkTick) begin
              swCnt <= 2'h1;
            end
            if (lsTick && swCnt != 2'h0) begin
              cpuClockSourceStatus <= 1'h0;
              swState              <= SW_IDLE;
            end
          end
        end
        default: begin
          swState <= SW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      switchBusy <= 1'h0;
    end else begin
      switchBusy <= (cpuClockSourceSelect != cpuClockSourceStatus);
    end
  end

  // CPU clock: selected source divided, stopped in STOP, HALT and start-up.
  assign srcTick = cpuClockSourceStatus ? hsTick : lsTick;
  assign cpuRun  = (phase == PH_RUN) & ~stopMode & ~haltMode;

  cpu_tick_divider #(
    .CNT_W (4)
  ) u_divider (
    .clk_sys    (clk_sys),
    .sys_rst    (blockRst),
    .srcTick    (srcTick),
    .runEnable  (cpuRun),
    .codeIn     (cpuDividerCode),
    .tickOut    (divTick),
    .activeCode (cpuDividerActive)
  );

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      cpuClkTick <= 1'h0;
    end else begin
      cpuClkTick <= divTick;
    end
  end

  // The select bit is frozen at HALT entry so the peripherals keep that source.
  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      haltSource <= `SRC_SELECT_RST;
    end else if (!haltMode) begin
      haltSource <= cpuClockSourceSelect;
    end
  end

  // Peripheral clock is the undivided source, absent in reset, start-up and STOP.
  always_comb begin
    next_periphTick = 1'h0;
    if (phase == PH_RUN && !stopMode) begin
      if (haltMode) begin
        next_periphTick = haltSource ? hsTick : lsTick;
      end else begin
        next_periphTick = srcTick;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      periphClkTick <= 1'h0;
    end else begin
      periphClkTick <= next_periphTick;
    end
  end

  // Watchdog on the low-speed clock. When the oscillator cannot be stopped it
  // keeps counting in STOP, so software must service it from a timer there.
  assign wdtRun = (phase == PH_RUN)
                  & ~(lowSpeedStoppable & (stopMode | haltMode));

  always_ff @(posedge clk_sys) begin
    if (blockRst) begin
      wdtCnt           <= 16'h0000;
      watchdogOverflow <= 1'h0;
    end else begin
      watchdogOverflow <= 1'h0;
      if (watchdogClear) begin
        wdtCnt <= 16'h0000;
      end else if (wdtRun && lsTick) begin
        if (wdtCnt == WDT_PERIOD - 16'h0001) begin
          wdtCnt           <= 16'h0000;
          watchdogOverflow <= 1'h1;
        end else begin
          wdtCnt <= wdtCnt + 16'h0001;
        end
      end
    end
  end

endmodule // cpu_clock_source_switcher

// [testbench/clk_switch_monitor.sv]
// Port-level assertions for the CPU clock source switcher.
`timescale 1ns/1ps
module clk_switch_monitor
  import clk_switch_pkg::*;
(
  input wire logic      clk_sys,              // Clock.
  input wire logic      sys_rst,              // Reset.
  input wire logic      resetPinN,            // Reset pin.
  input wire logic      lowSpeedStoppable,    // Option.
  input wire logic      stopMode,             // STOP.
  input wire logic      cpuClockSourceSelect, // Select.
  input wire logic      cpuClockSourceStatus, // Status.
  input wire logic      highSpeedOscStop,     // Stop flag.
  input wire div_code_t cpuDividerCode,       // Code.
  input wire div_code_t cpuDividerActive,     // Active code.
  input wire logic      highSpeedOscEnable,   // High enable.
  input wire logic      lowSpeedOscEnable,    // Low enable.
  input wire logic      cpuClkTick,           // CPU tick.
  input wire logic      periphClkTick,        // Peripheral tick.
  input wire logic      watchdogOverflow,     // Overflow.
  input wire logic      internalReset         // Reset out.
);
  // Bench oscillators give a ratio near 3.3, so a downward switch sees few ticks.
  localparam int DOWN_MAX = 6;
  logic [3:0] pendTicks;
  logic [3:0] divTicks;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // CPU clocks on the old source; saturates so it cannot wrap back to a legal value.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || cpuClockSourceSelect == cpuClockSourceStatus) begin
      pendTicks <= 4'h0;
    end else if (cpuClkTick && pendTicks != 4'hf) begin
      pendTicks <= pendTicks + 4'h1;
    end
  end

  // CPU clocks on the old division.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || cpuDividerCode == cpuDividerActive) begin
      divTicks <= 4'h0;
    end else if (cpuClkTick && divTicks != 4'hf) begin
      divTicks <= divTicks + 4'h1;
    end
  end

  property p_resetSource;
    $fell(resetPinN) |-> ##[1:5] internalReset;
  endproperty
  a_resetSource: assert property (p_resetSource) else $error("pin reset not seen");
  property p_resetQuiet;
    internalReset && $past(internalReset) |-> !cpuClockSourceSelect && !highSpeedOscEnable
      && !lowSpeedOscEnable && !cpuClkTick;
  endproperty
  a_resetQuiet: assert property (p_resetQuiet) else $error("clocks run in reset");
  property p_wdReset;
    watchdogOverflow |-> ##[1:4] internalReset;
  endproperty
  a_wdReset: assert property (p_wdReset) else $error("no reset after overflow");
  property p_oldClock;
    $rose(cpuClockSourceSelect) |-> !cpuClockSourceStatus;
  endproperty
  a_oldClock: assert property (p_oldClock) else $error("switch was immediate");
  property p_upBound;
    cpuClockSourceSelect && !cpuClockSourceStatus |-> pendTicks <= 4'h2;
  endproperty
  a_upBound: assert property (p_upBound) else $error("slow upward switch");
  property p_downBound;
    !cpuClockSourceSelect && cpuClockSourceStatus |-> pendTicks <= DOWN_MAX;
  endproperty
  a_downBound: assert property (p_downBound) else $error("slow downward switch");
  property p_hsStopAct;
    highSpeedOscStop && !cpuClockSourceStatus |=> !highSpeedOscEnable;
  endproperty
  a_hsStopAct: assert property (p_hsStopAct) else $error("high osc not stopped");
  property p_hsStopIgnored;
    cpuClockSourceStatus && !stopMode && !internalReset ##1
      cpuClockSourceStatus && !stopMode && !internalReset |-> highSpeedOscEnable;
  endproperty
  a_hsStopIgnored: assert property (p_hsStopIgnored) else $error("high osc lost");
  property p_stopQuiet;
    stopMode ##1 stopMode |=> !highSpeedOscEnable && !periphClkTick;
  endproperty
  a_stopQuiet: assert property (p_stopQuiet) else $error("clock runs in STOP");
  property p_lsRun;
    !lowSpeedStoppable && !internalReset ##1 !lowSpeedStoppable && !internalReset
      |-> lowSpeedOscEnable;
  endproperty
  a_lsRun: assert property (p_lsRun) else $error("low osc stopped");
  property p_divLatency;
    cpuDividerCode != cpuDividerActive |-> divTicks <= 4'h2;
  endproperty
  a_divLatency: assert property (p_divLatency) else $error("old division too long");

  c_up: cover property ($rose(cpuClockSourceStatus));
  c_down: cover property ($fell(cpuClockSourceStatus));
  c_wd: cover property (watchdogOverflow);
endmodule // clk_switch_monitor

bind cpu_clock_source_switcher clk_switch_monitor u_clk_switch_monitor (
  .clk_sys, .sys_rst, .resetPinN, .lowSpeedStoppable, .stopMode, .cpuClockSourceSelect,
  .cpuClockSourceStatus, .highSpeedOscStop, .cpuDividerCode, .cpuDividerActive,
  .highSpeedOscEnable, .lowSpeedOscEnable, .cpuClkTick, .periphClkTick,
  .watchdogOverflow, .internalReset);

// [testbench/tb.sv]
// Self-checking testbench for the CPU clock source switcher.
`timescale 1ns/1ps
`include "clk_switch_cfg.svh"
module tb;
  import clk_switch_pkg::*;
  logic      clk_sys = 1'b0, sys_rst = 1'b1, resetPinN = 1'b1;
  logic      powerOnClear = 1'b0, lowVoltageDetect = 1'b0, lowSpeedStoppable = 1'b0;
  logic      lowSpeedClkIn = 1'b0, crystalOscInput = 1'b0, stopMode = 1'b0;
  logic      selectWrite = 1'b0, selectData = 1'b0, hsStopWrite = 1'b0, hsStopData = 1'b0;
  logic      lsStopWrite = 1'b0, lsStopData = 1'b0, divWrite = 1'b0, haltMode = 1'b0;
  logic      watchdogClear = 1'b1;
  div_code_t divData = 3'h0, cpuDividerCode, cpuDividerActive;
  logic      cpuClockSourceSelect, cpuClockSourceStatus, highSpeedOscStop, lowSpeedOscStop;
  logic      highSpeedOscEnable, lowSpeedOscEnable, cpuClkTick, periphClkTick;
  logic      switchBusy, watchdogOverflow, internalReset;
  int        fails = 0, compares = 0, n;

  // Small watchdog period keeps the overflow scenario short.
  cpu_clock_source_switcher #(.WDT_PERIOD(16'h0008), .RST_HOLD(4'h8))
    u_cpu_clock_source_switcher (.*);

  // Oscillators run only while enabled and are offset so they never move on a clock edge.
  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    #2;
    forever #100 lowSpeedClkIn = (lowSpeedOscEnable === 1'b1) ? ~lowSpeedClkIn : 1'b0;
  end
  initial begin
    #1;
    forever #30 crystalOscInput = (highSpeedOscEnable === 1'b1) ? ~crystalOscInput : 1'b0;
  end

  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [2:0] probe(input int k);
    case (k)
      0: probe = {2'h0, cpuClockSourceStatus};
      1: probe = {2'h0, internalReset};
      2: probe = {2'h0, watchdogOverflow};
      3: probe = {2'h0, highSpeedOscEnable};
      4: probe = {2'h0, lowSpeedOscEnable};
      default: probe = cpuDividerActive;
    endcase
  endfunction

  // Bounded wait; a wait that runs out ends the run.
  task automatic waitOn(input int k, input logic [2:0] v, input int lim);
    int i;
    i = 0;
    while (probe(k) !== v && i < lim) begin
      @(negedge clk_sys);
      i++;
    end
    check({5'h0, probe(k)}, {5'h0, v});
    if (probe(k) !== v) results();
  endtask

  // One write strobe of one cycle, then a settled readback.
  task automatic wr(input int k, input logic [2:0] v);
    @(negedge clk_sys);
    case (k)
      0: {selectWrite, selectData} = {1'b1, v[0]};
      1: {hsStopWrite, hsStopData} = {1'b1, v[0]};
      2: {lsStopWrite, lsStopData} = {1'b1, v[0]};
      default: {divWrite, divData} = {1'b1, v};
    endcase
    @(negedge clk_sys);
    {selectWrite, hsStopWrite, lsStopWrite, divWrite} = 4'h0;
    @(negedge clk_sys);
  endtask

  task automatic countTicks(input int cycles);
    n = 0;
    repeat (cycles) begin
      @(negedge clk_sys);
      if (periphClkTick === 1'b1) n++;
    end
  endtask

  // Counts low-speed edges from reset release to the first CPU clock.
  task automatic startUp();
    logic prev;
    waitOn(1, 3'h0, 40);
    n = 0;
    prev = lowSpeedClkIn;
    for (int i = 0; i < 800 && cpuClkTick !== 1'b1; i++) begin
      @(negedge clk_sys);
      if (lowSpeedClkIn && !prev) n++;
      prev = lowSpeedClkIn;
    end
    check(8'(n >= 17 && n <= 18), 8'h1);
    if (cpuClkTick !== 1'b1) results();
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    check({internalReset, cpuClockSourceSelect, highSpeedOscStop, lowSpeedOscStop}, 8'h8);
    check({cpuDividerCode, highSpeedOscEnable, lowSpeedOscEnable}, 8'h0);
    sys_rst = 1'b0;
    startUp();
    // Each outside source resets the flags it reaches.
    for (int k = 0; k < 3; k++) begin
      wr(2, 3'h1);
      {resetPinN, powerOnClear, lowVoltageDetect} = (k == 0) ? 3'h0 : (k == 1) ? 3'h6 : 3'h5;
      waitOn(1, 3'h1, 10);
      {resetPinN, powerOnClear, lowVoltageDetect} = 3'h4;
      check({7'h0, lowSpeedOscStop}, 8'h0);
      startUp();
    end
    // The bench high-speed source is the internal one, so software waits its settle time.
    repeat (`HS_INT_WAIT_CYC) @(negedge clk_sys);
    wr(0, 3'h1);
    check({cpuClockSourceSelect, cpuClockSourceStatus, switchBusy}, 8'h5);
    waitOn(0, 3'h1, 200);
    wr(1, 3'h1);
    check({highSpeedOscStop, highSpeedOscEnable, switchBusy}, 8'h6);
    wr(1, 3'h0);
    lowSpeedStoppable = 1'b1;
    wr(2, 3'h1);
    waitOn(4, 3'h0, 5);
    lowSpeedStoppable = 1'b0;
    waitOn(4, 3'h1, 5);
    wr(2, 3'h0);
    // Every legal divider code, then a code that must be refused.
    for (int c = 0; c < 5; c++) begin
      wr(3, 3'(c));
      check({5'h0, cpuDividerCode}, 8'(c));
      waitOn(5, 3'(c), 300);
    end
    wr(3, 3'h5);
    check({5'h0, cpuDividerCode}, 8'h4);
    wr(3, 3'h1);
    waitOn(5, 3'h1, 300);
    // HALT keeps the peripheral clock on the selected source: 6 or 20 cycles a tick.
    for (int s = 1; s >= 0; s--) begin
      wr(0, 3'(s));
      waitOn(0, 3'(s), 200);
      haltMode = 1'b1;
      countTicks(400);
      haltMode = 1'b0;
      check(8'(s ? (n >= 64 && n <= 68) : (n >= 19 && n <= 21)), 8'h1);
    end
    wr(1, 3'h1);
    waitOn(3, 3'h0, 5);
    wr(1, 3'h0);
    waitOn(3, 3'h1, 5);
    // Long enough for several watchdog periods, so only the held clear keeps reset away.
    stopMode = 1'b1;
    countTicks(400);
    check({n[5:0], highSpeedOscEnable, lowSpeedOscEnable}, 8'h1);
    check({7'h0, internalReset}, 8'h0);
    watchdogClear = 1'b0;
    waitOn(2, 3'h1, 400);
    waitOn(1, 3'h1, 6);
    {stopMode, watchdogClear} = 2'h1;
    startUp();
    // A stoppable low-speed oscillator halts the watchdog in STOP.
    {lowSpeedStoppable, stopMode, watchdogClear} = 3'h6;
    countTicks(400);
    check({7'h0, internalReset}, 8'h0);
    results();
  end
endmodule // tb
